// ===== design/pic_irq_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module pirc_irq_ctrl
  import pirc_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_SRC-1:0]  srcReq,
  input  wire logic [NUM_TRAP-1:0] trapEvt,
  input  wire logic                trapDone,
  output logic                     cpuIrqReq,
  output logic      [6:0]          cpuVector,
  output logic      [3:0]          cpuLevel,
  output logic                     nestingDisable,
  output logic                     altVectorSel,
  output logic                     irqOut
);
  // Register storage
  logic [REG_W-1:0]     ctrlA_ff;
  logic [REG_W-1:0]     ctrlB_ff;
  logic [REG_W-1:0]     flag_ff [NUM_FLAG];
  logic [REG_W-1:0]     enable_ff [NUM_FLAG];
  logic [REG_W-1:0]     prio_ff [NUM_PRIO];
  logic [6:0]           vector_ff;
  logic [3:0]           level_ff;
  logic [2:0]           iplField_ff;
  logic                 iplMsb_ff;
  logic [NUM_EV-1:0]    evStat_ff;
  logic [NUM_EV-1:0]    evMask_ff;
  logic [NUM_SRC-1:0]   reqMeta_ff;
  logic [NUM_SRC-1:0]   reqSync_ff;
  logic [NUM_SRC-1:0]   reqLast_ff;
  logic [NUM_TRAP-1:0]  trapMeta_ff;
  logic [NUM_TRAP-1:0]  trapSync_ff;
  logic [31:0]          prdata_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;
  logic                 cpuIrqReq_ff;
  logic                 irqOut_ff;

  logic                 wrEn;
  logic                 rdEn;
  logic [NUM_SRC-1:0]   reqLevel;
  logic [NUM_SRC-1:0]   reqRise;
  logic [3:0]           curLevel;
  logic                 bestValid;
  logic [6:0]           bestIdx;
  logic [2:0]           bestPrio;
  logic                 presentReq;
  logic [NUM_EV-1:0]    evSet;
  logic [31:0]          nxt_prdata;
  logic                 nxt_pslverr;

  // Word index relative to a bank base, or an out-of-range value when outside it
  function automatic int bankIdx(input logic [11:0] addr, input logic [11:0] base, input int cnt);
    int idx;
    idx = -1;
    if (addr >= base && addr < base + 12'(cnt * 4) && addr[1:0] == 2'b00)
    begin
      idx = int'((addr - base) >> 2);
    end
    return idx;
  endfunction

  // Reads sampled one cycle before pready rises; writes commit in the cycle pready is high
  assign wrEn = psel & penable & pwrite & pready_ff;
  assign rdEn = psel & penable & ~pready_ff;

  // Pins come from outside the clock domain: two flops first
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      reqMeta_ff  <= '0;
      reqSync_ff  <= '0;
      reqLast_ff  <= '0;
      trapMeta_ff <= '0;
      trapSync_ff <= '0;
    end
    else
    begin
      reqMeta_ff  <= srcReq;
      reqSync_ff  <= reqMeta_ff;
      reqLast_ff  <= reqLevel;
      trapMeta_ff <= trapEvt;
      trapSync_ff <= trapMeta_ff;
    end
  end

  // External pins may be inverted; every source flags on its rising edge
  always_comb
  begin
    reqLevel = reqSync_ff;
    for (int e = 0; e < NUM_EXT; e++)
    begin
      reqLevel[EXT_IDX[e]] = reqSync_ff[EXT_IDX[e]] ^ ctrlB_ff[e];
    end
    reqRise = reqLevel & ~reqLast_ff;
  end

  // Global control registers; trap status bits set by hardware win over the write
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctrlA_ff <= ZERO16;
      ctrlB_ff <= ZERO16;
    end
    else
    begin
      if (wrEn && paddr == ADDR_CTRL_A)
      begin
        ctrlA_ff <= pwdata[REG_W-1:0];
      end
      if (wrEn && paddr == ADDR_CTRL_B)
      begin
        ctrlB_ff <= pwdata[REG_W-1:0];
      end
      for (int t = 0; t < NUM_TRAP; t++)
      begin
        if (trapSync_ff[t])
        begin
          ctrlA_ff[TRAP_LSB+t] <= 1'b1;
        end
      end
    end
  end

  // Request flags: software writes, a new request sets, set beats clear
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int r = 0; r < NUM_FLAG; r++)
      begin
        flag_ff[r] <= ZERO16;
      end
    end
    else
    begin
      for (int r = 0; r < NUM_FLAG; r++)
      begin
        logic [REG_W-1:0] base;
        base = (wrEn && bankIdx(paddr, ADDR_FLAG0, NUM_FLAG) == r) ? pwdata[REG_W-1:0] : flag_ff[r];
        for (int b = 0; b < REG_W; b++)
        begin
          if (r * REG_W + b < NUM_SRC && reqRise[r*REG_W+b])
          begin
            base[b] = 1'b1;
          end
        end
        flag_ff[r] <= base;
      end
    end
  end

  // Enable and priority banks, plain read-write storage
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int r = 0; r < NUM_FLAG; r++)
      begin
        enable_ff[r] <= ZERO16;
      end
      for (int r = 0; r < NUM_PRIO; r++)
      begin
        prio_ff[r] <= PRIO_RST;
      end
    end
    else
    begin
      for (int r = 0; r < NUM_FLAG; r++)
      begin
        if (wrEn && bankIdx(paddr, ADDR_EN0, NUM_FLAG) == r)
        begin
          enable_ff[r] <= pwdata[REG_W-1:0];
        end
      end
      for (int r = 0; r < NUM_PRIO; r++)
      begin
        if (wrEn && bankIdx(paddr, ADDR_PRIO0, NUM_PRIO) == r)
        begin
          prio_ff[r] <= pwdata[REG_W-1:0];
        end
      end
    end
  end

  // CPU level: low field writable, msb only follows traps
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      iplField_ff <= 3'h0;
      iplMsb_ff   <= 1'b0;
    end
    else
    begin
      if (wrEn && paddr == ADDR_STATUS)
      begin
        iplField_ff <= pwdata[IPL_LSB+2:IPL_LSB];
      end
      if (|trapSync_ff)
      begin
        iplMsb_ff <= 1'b1;
      end
      else if (trapDone)
      begin
        iplMsb_ff <= 1'b0;
      end
    end
  end

  assign curLevel = {iplMsb_ff, iplField_ff};

  // Scan from the top down so the lowest position wins a tie
  always_comb
  begin
    bestValid = 1'b0;
    bestIdx   = 7'h00;
    bestPrio  = 3'h0;
    for (int s = NUM_SRC - 1; s >= 0; s--)
    begin
      logic [2:0] p;
      p = prio_ff[s/FIELDS][(s%FIELDS)*4 +: 3];
      if (flag_ff[s/REG_W][s%REG_W] && enable_ff[s/REG_W][s%REG_W] && p != 3'h0 && p >= bestPrio)
      begin
        bestValid = 1'b1;
        bestIdx   = 7'(s);
        bestPrio  = p;
      end
    end
    presentReq = bestValid && ({1'b0, bestPrio} > curLevel);
  end

  // Pending vector latched whenever a request is presented
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      vector_ff    <= 7'h00;
      level_ff     <= 4'h0;
      cpuIrqReq_ff <= 1'b0;
    end
    else
    begin
      cpuIrqReq_ff <= presentReq;
      if (presentReq)
      begin
        vector_ff <= VEC_BASE + bestIdx;
        level_ff  <= {1'b0, bestPrio};
      end
    end
  end

  // Event status: new vector and trap; set wins over write-one-clear
  assign evSet[EV_NEWVEC] = presentReq && (!cpuIrqReq_ff || vector_ff != VEC_BASE + bestIdx);
  assign evSet[EV_TRAP]   = |trapSync_ff;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      evStat_ff <= '0;
      evMask_ff <= '0;
      irqOut_ff <= 1'b0;
    end
    else
    begin
      if (wrEn && paddr == ADDR_IRQMASK)
      begin
        evMask_ff <= pwdata[NUM_EV-1:0];
      end
      if (wrEn && paddr == ADDR_IRQSTAT)
      begin
        evStat_ff <= (evStat_ff & ~pwdata[NUM_EV-1:0]) | evSet;
      end
      else
      begin
        evStat_ff <= evStat_ff | evSet;
      end
      irqOut_ff <= |(evStat_ff & evMask_ff);
    end
  end

  // Read mux; unmapped words read zero with an error
  always_comb
  begin
    int fi;
    int ei;
    int pi;
    fi = bankIdx(paddr, ADDR_FLAG0, NUM_FLAG);
    ei = bankIdx(paddr, ADDR_EN0, NUM_FLAG);
    pi = bankIdx(paddr, ADDR_PRIO0, NUM_PRIO);
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (paddr == ADDR_CTRL_A)
      nxt_prdata[REG_W-1:0] = ctrlA_ff;
    else if (paddr == ADDR_CTRL_B)
      nxt_prdata[REG_W-1:0] = ctrlB_ff;
    else if (fi >= 0)
      nxt_prdata[REG_W-1:0] = flag_ff[fi];
    else if (ei >= 0)
      nxt_prdata[REG_W-1:0] = enable_ff[ei];
    else if (pi >= 0)
      nxt_prdata[REG_W-1:0] = prio_ff[pi];
    else if (paddr == ADDR_PEND)
    begin
      nxt_prdata[6:0] = vector_ff;
      nxt_prdata[PEND_LVL_LSB +: 4] = level_ff;
    end
    else if (paddr == ADDR_STATUS)
      nxt_prdata[IPL_LSB +: 3] = iplField_ff;
    else if (paddr == ADDR_CORE)
      nxt_prdata[CPU_PRIORITY_MSB_BIT] = iplMsb_ff;
    else if (paddr == ADDR_IRQSTAT)
      nxt_prdata[NUM_EV-1:0] = evStat_ff;
    else if (paddr == ADDR_IRQMASK)
      nxt_prdata[NUM_EV-1:0] = evMask_ff;
    else
      nxt_pslverr = 1'b1;
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= rdEn;
      pslverr_ff <= rdEn & nxt_pslverr;
      if (rdEn && !pwrite)
      begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign cpuIrqReq      = cpuIrqReq_ff;
  assign cpuVector      = vector_ff;
  assign cpuLevel       = level_ff;
  assign nestingDisable = ctrlA_ff[NEST_BIT];
  assign altVectorSel   = ctrlB_ff[ALTVEC_BIT];
  assign irqOut         = irqOut_ff;
endmodule
`default_nettype wire

// ===== shared/pic_pkg.sv
package pirc_pkg;
  localparam int REG_W      = 16;
  localparam int NUM_FLAG   = 5;
  localparam int NUM_PRIO   = 18;
  localparam int FIELDS     = 4;
  localparam int NUM_SRC    = NUM_PRIO * FIELDS;
  localparam int NUM_EXT    = 5;
  localparam int NUM_TRAP   = 4;
  localparam logic [6:0] VEC_BASE = 7'h08;
  // Byte offsets of each register word
  localparam logic [11:0] ADDR_CTRL_A  = 12'h000;
  localparam logic [11:0] ADDR_CTRL_B  = 12'h004;
  localparam logic [11:0] ADDR_FLAG0   = 12'h008;
  localparam logic [11:0] ADDR_EN0     = 12'h01c;
  localparam logic [11:0] ADDR_PRIO0   = 12'h030;
  localparam logic [11:0] ADDR_PEND    = 12'h078;
  localparam logic [11:0] ADDR_STATUS  = 12'h07c;
  localparam logic [11:0] ADDR_CORE    = 12'h080;
  localparam logic [11:0] ADDR_IRQSTAT = 12'h084;
  localparam logic [11:0] ADDR_IRQMASK = 12'h088;
  // Field positions
  localparam int NEST_BIT     = 15;
  localparam int TRAP_LSB     = 1;
  localparam int ALTVEC_BIT   = 15;
  localparam int IPL_LSB      = 5;
  localparam int CPU_PRIORITY_MSB_BIT     = 3;
  localparam int PEND_LVL_LSB = 8;
  localparam int EV_NEWVEC    = 0;
  localparam int EV_TRAP      = 1;
  localparam int NUM_EV       = 2;
  // Reset values
  localparam logic [15:0] PRIO_RST = 16'h4444;
  localparam logic [15:0] ZERO16   = 16'h0000;
  // Flag positions of the external request pins
  localparam int EXT_IDX [NUM_EXT] = '{0, 13, 29, 45, 60};
endpackage

// ===== tb/pirc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pirc_checker
  import pirc_pkg::*;
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic [11:0] paddr,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpuIrqReq,
  input wire logic [6:0]  cpuVector,
  input wire logic [3:0]  cpuLevel,
  input wire logic        nestingDisable,
  input wire logic        altVectorSel
);
  // Single domain, so reset masks every check
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  AST_ACC_ANSWER: assert property (psel && penable && !pready |=> pready)
    else $error("late ready");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held");
  AST_ERR_UNMAPPED: assert property (pready && paddr > ADDR_IRQMASK |-> pslverr)
    else $error("no error");
  AST_HIGH_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper bits");
  // Controls move only on a committed write to their word
  AST_NEST_HOLD: assert property (!(pready && pwrite && paddr == ADDR_CTRL_A) |=> $stable(nestingDisable))
    else $error("nesting moved");
  AST_ALT_HOLD: assert property (!(pready && pwrite && paddr == ADDR_CTRL_B) |=> $stable(altVectorSel))
    else $error("alt moved");
  AST_LVL_RANGE: assert property (cpuIrqReq |-> cpuLevel inside {[4'h1:4'h7]})
    else $error("bad level");
  AST_VEC_RANGE: assert property (cpuIrqReq |-> cpuVector >= VEC_BASE && cpuVector < 7'h50)
    else $error("bad vector");
endmodule
bind pirc_irq_ctrl pirc_checker chk_i (.clock, .srst, .paddr, .pwrite, .prdata, .psel, .penable, .pready,
  .pslverr, .cpuIrqReq, .cpuVector, .cpuLevel, .nestingDisable, .altVectorSel);
`default_nettype wire

// ===== tb/pirc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module pirc_cpu_model
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        cpuIrqReq,
  input wire logic [6:0]  cpuVector,
  input wire logic        retire,
  input wire logic        slow,
  output logic            trapDone,
  output logic      [6:0] takenVec
);
  int cnt;

  // Trap return pulse after a short or long handler
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cnt      <= 0;
      trapDone <= 1'b0;
      takenVec <= 7'h00;
    end
    else
    begin
      trapDone <= (cnt == 1);
      if (retire)
        cnt <= slow ? 4 : 1;
      else if (cnt != 0)
        cnt <= cnt - 1;
      if (cpuIrqReq)
        takenVec <= cpuVector;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_prioritized_interrupt_controller.sv
`timescale 1ns/100ps
`default_nettype none
module tb_prioritized_interrupt_controller
  import pirc_pkg::*;
;
  logic                clock, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata;
  logic [NUM_SRC-1:0]  srcReq;
  logic [NUM_TRAP-1:0] trapEvt;
  logic [6:0]          cpuVector, takenVec;
  logic [3:0]          cpuLevel;
  logic                cpuIrqReq, trapDone, nestingDisable, altVectorSel, irqOut, retire, slow;
  int                  mismatches, checks, seed, s, p, ipl, msb;
  int                  fl[80] = '{default: 0};
  int                  en[80] = '{default: 0};
  int                  pr[80] = '{default: 4};

  pirc_irq_ctrl uut (.clock, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .srcReq, .trapEvt, .trapDone, .cpuIrqReq, .cpuVector, .cpuLevel, .nestingDisable, .altVectorSel, .irqOut);
  pirc_cpu_model cpu (.clock, .srst, .cpuIrqReq, .cpuVector, .retire, .slow, .trapDone, .takenVec);

  // 200 MHz system clock
  always #2.5 clock = ~clock;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One bus cycle; request held until ready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (int n = 0; n < 16 && pready !== 1'b1; n++)
      @(posedge clock);
    if (pready !== 1'b1)
    begin
      chk("pready", 32'h1, {31'h0, pready});
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, r, e);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask

  // Reference pick: strict compare keeps the lowest index on ties
  function automatic int best();
    int b;
    b = -1;
    for (int i = 0; i < NUM_SRC; i++)
      if (fl[i] != 0 && en[i] != 0 && pr[i] > ipl + 8 * msb && (b < 0 || pr[i] > pr[b]))
        b = i;
    return b;
  endfunction

  task automatic cmp();
    int b;
    repeat (2) @(posedge clock);
    b = best();
    chk("cpuIrqReq", {31'h0, b >= 0}, {31'h0, cpuIrqReq});
    if (b >= 0)
    begin
      chk("cpuVector", 32'(b + VEC_BASE), {25'h0, cpuVector});
      chk("cpuLevel", 32'(pr[b]), {28'h0, cpuLevel});
      rd(ADDR_PEND, 32'(pr[b] * 256 + b + VEC_BASE), 1'b0);
    end
  endtask

  task automatic setsrc(input int n, input int q);
    logic [15:0] v;
    en[n] = 1;
    pr[n] = q;
    for (int i = 0; i < 16; i++)
      v[i] = en[n / 16 * 16 + i] != 0;
    wr(12'(ADDR_EN0 + n / 16 * 4), {16'h0, v});
    for (int i = 0; i < 4; i++)
      v[i * 4 +: 4] = 4'(pr[n / 4 * 4 + i]);
    wr(12'(ADDR_PRIO0 + n / 4 * 4), {16'h0, v});
  endtask

  task automatic raise(input int n);
    srcReq[n] <= 1'b1;
    repeat (6) @(posedge clock);
    srcReq[n] <= 1'b0;
    fl[n] = 1;
  endtask

  // Clearing writes a whole flag word, so all its sixteen flags drop
  task automatic clr(input int n);
    for (int i = 0; i < 16; i++)
      fl[n / 16 * 16 + i] = 0;
    wr(12'(ADDR_FLAG0 + n / 16 * 4), 32'h0);
  endtask

  task automatic setipl(input int l);
    ipl = l;
    wr(ADDR_STATUS, 32'(l) << IPL_LSB);
  endtask

  initial
  begin
    clock = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    srcReq = '0;
    trapEvt = '0;
    retire = 1'b0;
    slow = 1'b0;
    mismatches = 0;
    checks = 0;
    seed = 85820;
    ipl = 0;
    msb = 0;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(ADDR_PRIO0, 32'h4444, 1'b0);
    rd(ADDR_FLAG0, 32'h0, 1'b0);
    rd(12'h08c, 32'h0, 1'b1);
    wr(ADDR_CORE, 32'h8);
    rd(ADDR_CORE, 32'h0, 1'b0);
    repeat (4)
    begin
      s = ($random(seed) & 32'h7fffffff) % NUM_SRC;
      p = 1 + ($random(seed) & 32'h7fffffff) % 7;
      setipl($random(seed) & 32'h7);
      setsrc(s, p);
      raise(s);
      cmp();
      rd(12'(ADDR_FLAG0 + s / 16 * 4), 32'h1 << (s % 16), 1'b0);
      clr(s);
      cmp();
    end
    setipl(0);
    setsrc(40, 5);
    setsrc(10, 5);
    raise(40);
    raise(10);
    cmp();
    setsrc(10, 0);
    cmp();
    setipl(5);
    rd(ADDR_STATUS, 32'h00a0, 1'b0);
    cmp();
    setipl(1);
    trapEvt <= 4'h1;
    repeat (4) @(posedge clock);
    trapEvt <= 4'h0;
    msb = 1;
    cmp();
    rd(ADDR_CORE, 32'h8, 1'b0);
    rd(ADDR_CTRL_A, 32'h2, 1'b0);
    slow <= 1'b1;
    retire <= 1'b1;
    @(posedge clock);
    retire <= 1'b0;
    repeat (8) @(posedge clock);
    msb = 0;
    cmp();
    chk("takenVec", 32'd48, {25'h0, takenVec});
    rd(ADDR_IRQSTAT, 32'h3, 1'b0);
    wr(ADDR_IRQMASK, 32'h1);
    repeat (2) @(posedge clock);
    chk("irqOut", 32'h1, {31'h0, irqOut});
    clr(40);
    wr(ADDR_IRQSTAT, 32'h3);
    repeat (2) @(posedge clock);
    chk("irqOut", 32'h0, {31'h0, irqOut});
    wr(ADDR_CTRL_A, 32'h8000);
    chk("nestingDisable", 32'h1, {31'h0, nestingDisable});
    // Pin zero inverted: idle is high, so only a falling pin may raise its flag
    srcReq[0] <= 1'b1;
    repeat (4) @(posedge clock);
    clr(0);
    wr(ADDR_CTRL_B, 32'h8001);
    chk("altVectorSel", 32'h1, {31'h0, altVectorSel});
    srcReq[0] <= 1'b0;
    fl[0] = 1;
    repeat (4) @(posedge clock);
    rd(ADDR_FLAG0, 32'h1, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
